// ### rtl/rtc_cfg.svh
`ifndef RTC_CFG_SVH
`define RTC_CFG_SVH

`define DEV_ADDR 7'h68
`define PTR_SEC 3'h0
`define PTR_MIN 3'h1
`define PTR_CMON 3'h5
`define PTR_TRIM 3'h7
`define HALT_BIT 7
`define FAIL_IE_BIT 7
`define CLK_PERIOD_NS 100
`define SECOND_NS 1000000000

`define CMD_OFS 8'h00
`define STAT_OFS 8'h04
`define DIV_OFS 8'h08
`define CMD_START_BIT 8
`define CMD_STOP_BIT 9
`define CMD_READ_BIT 10
`define CMD_ACK_BIT 11
`define DIV_RESET 16'h0018
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// ### rtl/rtc_pkg.sv
package rtc_pkg;

typedef logic [7:0] byte_t;

typedef enum logic [6:0] {
    D_IDLE = 7'h01,
    D_ADDR = 7'h02,
    D_WORD = 7'h04,
    D_WRITE = 7'h08,
    D_ACK = 7'h10,
    D_READ = 7'h20,
    D_RACK = 7'h40
} dev_state_t;

typedef enum logic [3:0] {
    H_IDLE = 4'h1,
    H_START = 4'h2,
    H_BIT = 4'h4,
    H_STOP = 4'h8
} host_state_t;

endpackage

// ### rtl/rtc_link_if.sv
`timescale 1ns/1ps

interface rtc_link_if;
    logic sclOut;
    logic sclOe;
    logic sdaHostOut;
    logic sdaHostOe;
    logic sdaDevOut;
    logic sdaDevOe;
    logic scl;
    logic sda;

    // Wired AND with pull-ups: a line is low only while someone drives low
    assign scl = ~(sclOe & ~sclOut);
    assign sda = ~((sdaHostOe & ~sdaHostOut) | (sdaDevOe & ~sdaDevOut));

    modport host (output sclOut, sclOe, sdaHostOut, sdaHostOe, input scl, sda);
    modport dev (output sdaDevOut, sdaDevOe, input scl, sda);
endinterface

// ### rtl/rtc_time_keeper.sv
`timescale 1ns/1ps
`include "rtc_cfg.svh"

module rtc_time_keeper import rtc_pkg::*; #(
    parameter int unsigned TICKS = 10000000
) (
    // Clock and reset
    input wire logic clock,
    input wire logic nrst,
    // Register load
    input wire logic load,
    input wire logic [2:0] loadIdx,
    input wire byte_t loadData,
    // Live time
    output logic [6:0][7:0] liveQ,
    output logic tickQ
);

function automatic byte_t bcdInc(input byte_t v, input byte_t top, input byte_t low);
    if (v == top) begin
        return low;
    end
    if (v[3:0] == 4'h9) begin
        return {v[7:4] + 4'h1, 4'h0};
    end
    return v + 8'h01;
endfunction

////////////////////////////////////////////////////////////////////////////////

logic [31:0] divQ;

wire byte_t sec = {1'b0, liveQ[0][6:0]};
wire byte_t mins = {1'b0, liveQ[1][6:0]};
wire byte_t hrs = {2'b0, liveQ[2][5:0]};
wire byte_t dow = {5'b0, liveQ[3][2:0]};
wire byte_t dom = {2'b0, liveQ[4][5:0]};
wire byte_t mon = {3'b0, liveQ[5][4:0]};
wire byte_t yr = liveQ[6];
wire [1:0] cent = liveQ[5][7:6];
wire halted = liveQ[`PTR_SEC][`HALT_BIT];
// Year 00 is a leap year only in century 0
wire leap = (yr == 8'h00) ? (cent == 2'b00) : (yr[4] ?
    (yr[3:0] == 4'h2 || yr[3:0] == 4'h6) :
    (yr[3:0] == 4'h0 || yr[3:0] == 4'h4 || yr[3:0] == 4'h8));
wire byte_t lastDay = (mon == 8'h02) ? (leap ? 8'h29 : 8'h28) :
    ((mon == 8'h04 || mon == 8'h06 || mon == 8'h09 || mon == 8'h11) ? 8'h30 : 8'h31);
wire tick = ~halted && divQ == TICKS - 1;
wire c0 = tick && sec == 8'h59;
wire c1 = c0 && mins == 8'h59;
wire c2 = c1 && hrs == 8'h23;
wire c3 = c2 && dom == lastDay;
wire c4 = c3 && mon == 8'h12;
wire c5 = c4 && yr == 8'h99;
wire byte_t secN = bcdInc(sec, 8'h59, 8'h00);
wire byte_t minN = bcdInc(mins, 8'h59, 8'h00);
wire byte_t hrN = bcdInc(hrs, 8'h23, 8'h00);
wire byte_t dowN = bcdInc(dow, 8'h07, 8'h01);
wire byte_t domN = bcdInc(dom, lastDay, 8'h01);
wire byte_t monN = bcdInc(mon, 8'h12, 8'h01);
wire byte_t yrN = bcdInc(yr, 8'h99, 8'h00);
wire [1:0] centN = cent + 2'b01;

////////////////////////////////////////////////////////////////////////////////

always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
        divQ <= 32'h0;
        liveQ <= '0;
        tickQ <= 1'b0;
    end else begin
        tickQ <= tick;
        if (load) begin
            liveQ[loadIdx] <= loadData;
            divQ <= 32'h0;
        end else begin
            divQ <= (halted || tick) ? 32'h0 : divQ + 32'h1;
            if (tick) liveQ[0][6:0] <= secN[6:0];
            if (c0) liveQ[1][6:0] <= minN[6:0];
            if (c1) liveQ[2][5:0] <= hrN[5:0];
            if (c2) liveQ[3][2:0] <= dowN[2:0];
            if (c2) liveQ[4][5:0] <= domN[5:0];
            if (c3) liveQ[5][4:0] <= monN[4:0];
            if (c4) liveQ[6] <= yrN;
            if (c5) liveQ[5][7:6] <= centN;
        end
    end
end

endmodule

// ### rtl/rtc_device.sv
`timescale 1ns/1ps
`include "rtc_cfg.svh"

// Functional notes
// - START then matching slave address selects device
// - Eight byte registers in fixed order
// - Transfers start only from idle bus
// - Data falling while clock high is START
// - Data rising while clock high is STOP
// - Data stable while clock high, one pulse/bit
// - Eight-bit bytes, ninth bit acknowledges low
// - No limit on bytes between START/STOP
// - Device acknowledges address, word and data bytes
// - Master receiver acknowledges all but last byte
// - On missing acknowledge device releases data
// - Pointer set by write, repeated START reads
// - Read pointer advances only on acknowledge
// - Clock registers frozen while reading clock addresses
// - Plain read starts at stored pointer
// - Write loads pointer, stores bytes, increments
// - Time and calendar kept in BCD
// - Halt bit stops the oscillator
// - Software pulses halt bit after power-up
// - Writes to clock bytes reload clock, divider
// - Century bits sit above the month
// - Weekday low bits, fail enable minutes bit 7
module rtc_device import rtc_pkg::*; #(
    parameter int unsigned SECOND_TICKS = `SECOND_NS / `CLK_PERIOD_NS
) (
    // Clock and reset
    input wire logic clock,
    input wire logic nrst,
    // Serial link
    rtc_link_if.dev link,
    // User side status
    output logic haltOsc,
    output logic failIrqEnable,
    output byte_t rateTrim,
    output logic secondTick
);

////////////////////////////////////////////////////////////////////////////////

logic sclQ;
logic sdaQ;
dev_state_t stateQ;
dev_state_t afterQ;
logic [2:0] bitCntQ;
logic [2:0] ptrQ;
logic fullQ;
logic readingQ;
logic nackQ;
logic incOnAckQ;
logic sdaOeQ;
byte_t shiftQ;
byte_t regQ [0:7];
logic [6:0][7:0] live;

////////////////////////////////////////////////////////////////////////////////

// Pins are synchronous, so one stage is enough for edge detection
wire sclRise = link.scl & ~sclQ;
wire sclFall = ~link.scl & sclQ;
wire startCond = sclQ & link.scl & sdaQ & ~link.sda;
wire stopCond = sclQ & link.scl & ~sdaQ & link.sda;
wire byte_t rxByte = {shiftQ[6:0], link.sda};
wire inByte = (stateQ == D_ADDR) | (stateQ == D_WORD) | (stateQ == D_WRITE) |
    (stateQ == D_READ);
wire addrHit = shiftQ[7:1] == `DEV_ADDR;
wire wrTake = sclFall & fullQ & (stateQ == D_WRITE);
wire [2:0] ptrNext = ptrQ + 3'h1;
wire byte_t readNow = regQ[ptrQ];
wire byte_t readNext = regQ[ptrNext];
wire frozen = readingQ & (ptrQ != `PTR_TRIM);
wire clockWrite = wrTake & (ptrQ != `PTR_TRIM);

assign link.sdaDevOut = 1'b0;
assign link.sdaDevOe = sdaOeQ;
assign haltOsc = live[`PTR_SEC][`HALT_BIT];
assign failIrqEnable = live[`PTR_MIN][`FAIL_IE_BIT];
assign rateTrim = regQ[`PTR_TRIM];

////////////////////////////////////////////////////////////////////////////////

rtc_time_keeper #(
    .TICKS(SECOND_TICKS)
) keeper (
    .clock(clock),
    .nrst(nrst),
    .load(clockWrite),
    .loadIdx(ptrQ),
    .loadData(shiftQ),
    .liveQ(live),
    .tickQ(secondTick)
);

////////////////////////////////////////////////////////////////////////////////

// Readable image: clock bytes follow the live counters unless frozen
for (genvar i = 0; i < 8; i++) begin : gen_image
    if (i == int'(`PTR_TRIM)) begin : g_trim
        always_ff @(posedge clock or negedge nrst) begin
            if (!nrst) begin
                regQ[i] <= 8'h00;
            end else if (wrTake && ptrQ == `PTR_TRIM) begin
                regQ[i] <= shiftQ;
            end
        end
    end else begin : g_clock
        // Counters keep running while frozen, the image catches up on release
        always_ff @(posedge clock or negedge nrst) begin
            if (!nrst) begin
                regQ[i] <= 8'h00;
            end else if (!frozen) begin
                regQ[i] <= live[i];
            end
        end
    end
end

////////////////////////////////////////////////////////////////////////////////

always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
        sclQ <= 1'b1;
        sdaQ <= 1'b1;
    end else begin
        sclQ <= link.scl;
        sdaQ <= link.sda;
    end
end

////////////////////////////////////////////////////////////////////////////////

always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
        stateQ <= D_IDLE;
        afterQ <= D_IDLE;
        bitCntQ <= 3'h0;
        ptrQ <= 3'h0;
        fullQ <= 1'b0;
        readingQ <= 1'b0;
        nackQ <= 1'b0;
        incOnAckQ <= 1'b0;
        sdaOeQ <= 1'b0;
        shiftQ <= 8'h00;
    end else if (stopCond) begin
        // Bus back to idle; only a START leaves it
        stateQ <= D_IDLE;
        sdaOeQ <= 1'b0;
        readingQ <= 1'b0;
    end else if (startCond) begin
        stateQ <= D_ADDR;
        bitCntQ <= 3'h0;
        fullQ <= 1'b0;
        sdaOeQ <= 1'b0;
        readingQ <= 1'b0;
    end else if (sclRise) begin
        // Sample only at the rising edge, data settles while low
        if (inByte) begin
            shiftQ <= rxByte;
            bitCntQ <= bitCntQ + 3'h1;
            fullQ <= bitCntQ == 3'h7;
        end
        if (stateQ == D_RACK) begin
            nackQ <= link.sda;
        end
    end else if (sclFall) begin
        case (stateQ)
            D_ADDR: begin
                if (fullQ && addrHit) begin
                    afterQ <= shiftQ[0] ? D_READ : D_WORD;
                    incOnAckQ <= 1'b0;
                    stateQ <= D_ACK;
                    sdaOeQ <= 1'b1;
                end else if (fullQ) begin
                    stateQ <= D_IDLE;
                end
            end
            D_WORD: begin
                if (fullQ) begin
                    ptrQ <= shiftQ[2:0];
                    afterQ <= D_WRITE;
                    incOnAckQ <= 1'b0;
                    stateQ <= D_ACK;
                    sdaOeQ <= 1'b1;
                end
            end
            D_WRITE: begin
                if (fullQ) begin
                    afterQ <= D_WRITE;
                    incOnAckQ <= 1'b1;
                    stateQ <= D_ACK;
                    sdaOeQ <= 1'b1;
                end
            end
            D_ACK: begin
                // End of the acknowledge clock
                sdaOeQ <= 1'b0;
                fullQ <= 1'b0;
                bitCntQ <= 3'h0;
                stateQ <= afterQ;
                if (incOnAckQ) begin
                    ptrQ <= ptrNext;
                end
                if (afterQ == D_READ) begin
                    shiftQ <= readNow;
                    sdaOeQ <= ~readNow[7];
                    readingQ <= 1'b1;
                end
            end
            D_READ: begin
                if (fullQ) begin
                    stateQ <= D_RACK;
                    sdaOeQ <= 1'b0;
                end else begin
                    sdaOeQ <= ~shiftQ[7];
                end
            end
            D_RACK: begin
                if (!nackQ) begin
                    ptrQ <= ptrNext;
                    shiftQ <= readNext;
                    sdaOeQ <= ~readNext[7];
                    fullQ <= 1'b0;
                    bitCntQ <= 3'h0;
                    stateQ <= D_READ;
                end else begin
                    // Line stays released so the master can STOP
                    stateQ <= D_IDLE;
                    readingQ <= 1'b0;
                end
            end
            default: begin
                stateQ <= stateQ;
            end
        endcase
    end
end

endmodule

// ### rtl/rtc_host.sv
// Implementation choice: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`include "rtc_cfg.svh"

module rtc_host import rtc_pkg::*; #(
    parameter int unsigned ADDR_W = 8
) (
    // Clock and reset
    input wire logic clock,
    input wire logic nrst,
    // Write channels
    input wire logic [ADDR_W-1:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    // Read channels
    input wire logic [ADDR_W-1:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    // Serial link
    rtc_link_if.host link
);

////////////////////////////////////////////////////////////////////////////////

logic [11:0] cmdQ;
logic [15:0] divQ;
logic [15:0] cntQ;
byte_t rxQ;
byte_t txQ;
logic nackQ;
logic busyQ;
host_state_t stateQ;
logic [1:0] stepQ;
logic [3:0] bitIdxQ;
logic sclOeQ;
logic sdaOeQ;

wire wrGo = awready & awvalid & wvalid;
wire wrCmd = awaddr == ADDR_W'(`CMD_OFS);
wire wrDiv = awaddr == ADDR_W'(`DIV_OFS);
wire [31:0] lanes = {{8{wstrb[3]}}, {8{wstrb[2]}}, {8{wstrb[1]}}, {8{wstrb[0]}}};
wire [31:0] cmdMerged = ({20'h0, cmdQ} & ~lanes) | (wdata & lanes);
wire [31:0] divMerged = ({16'h0, divQ} & ~lanes) | (wdata & lanes);
// Commands written while busy are dropped; software polls busy first
wire cmdGo = wrGo & wrCmd & ~busyQ;
wire rdCmd = araddr == ADDR_W'(`CMD_OFS);
wire rdStat = araddr == ADDR_W'(`STAT_OFS);
wire rdDiv = araddr == ADDR_W'(`DIV_OFS);
wire [31:0] rdWord = rdCmd ? {20'h0, cmdQ} :
    (rdStat ? {22'h0, busyQ, nackQ, rxQ} : (rdDiv ? {16'h0, divQ} : 32'h0));
wire stepTick = cntQ == divQ;
wire lastBit = bitIdxQ == 4'h8;
wire isRead = cmdQ[`CMD_READ_BIT];
wire driveLow = lastBit ? (isRead & cmdQ[`CMD_ACK_BIT]) : (~isRead & ~txQ[7]);
wire busIdle = link.scl & link.sda;

assign link.sclOut = 1'b0;
assign link.sclOe = sclOeQ;
assign link.sdaHostOut = 1'b0;
assign link.sdaHostOe = sdaOeQ;

////////////////////////////////////////////////////////////////////////////////

always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
        awready <= 1'b0;
        wready <= 1'b0;
        bvalid <= 1'b0;
        bresp <= `RESP_OKAY;
        arready <= 1'b0;
        rvalid <= 1'b0;
        rdata <= 32'h0;
        rresp <= `RESP_OKAY;
        divQ <= `DIV_RESET;
    end else begin
        // Both write channels are taken together in one beat
        awready <= awvalid & wvalid & ~awready & ~bvalid;
        wready <= awvalid & wvalid & ~wready & ~bvalid;
        arready <= arvalid & ~arready & ~rvalid;
        if (wrGo) begin
            bvalid <= 1'b1;
            bresp <= (wrCmd | wrDiv) ? `RESP_OKAY : `RESP_SLVERR;
        end else if (bready) begin
            bvalid <= 1'b0;
        end
        if (wrGo && wrDiv) begin
            divQ <= divMerged[15:0];
        end
        if (arready && arvalid) begin
            rvalid <= 1'b1;
            rdata <= rdWord;
            rresp <= (rdCmd | rdStat | rdDiv) ? `RESP_OKAY : `RESP_SLVERR;
        end else if (rready) begin
            rvalid <= 1'b0;
        end
    end
end

////////////////////////////////////////////////////////////////////////////////

always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
        cmdQ <= 12'h0;
        cntQ <= 16'h0;
        rxQ <= 8'h00;
        txQ <= 8'h00;
        nackQ <= 1'b0;
        busyQ <= 1'b0;
        stateQ <= H_IDLE;
        stepQ <= 2'h0;
        bitIdxQ <= 4'h0;
        sclOeQ <= 1'b0;
        sdaOeQ <= 1'b0;
    end else begin
        cntQ <= (stepTick || stateQ == H_IDLE) ? 16'h0 : cntQ + 16'h1;
        if (cmdGo) begin
            cmdQ <= cmdMerged[11:0];
            txQ <= cmdMerged[7:0];
            busyQ <= 1'b1;
            stepQ <= 2'h0;
            bitIdxQ <= 4'h0;
            stateQ <= cmdMerged[`CMD_START_BIT] ? H_START : H_BIT;
        end else if (stepTick) begin
            case (stateQ)
                H_START: begin
                    case (stepQ)
                        2'h0: begin
                            sclOeQ <= 1'b0;
                            sdaOeQ <= 1'b0;
                            stepQ <= busIdle ? 2'h1 : 2'h0;
                        end
                        2'h1: begin
                            sdaOeQ <= 1'b1;
                            stepQ <= 2'h2;
                        end
                        default: begin
                            sclOeQ <= 1'b1;
                            stepQ <= 2'h0;
                            stateQ <= H_BIT;
                        end
                    endcase
                end
                H_BIT: begin
                    case (stepQ)
                        2'h0: begin
                            sdaOeQ <= driveLow;
                            stepQ <= 2'h1;
                        end
                        2'h1: begin
                            sclOeQ <= 1'b0;
                            stepQ <= 2'h2;
                        end
                        2'h2: begin
                            // Wait while the clock line is still held low
                            if (link.scl && !lastBit) begin
                                rxQ <= {rxQ[6:0], link.sda};
                            end
                            if (link.scl && lastBit) begin
                                nackQ <= link.sda;
                            end
                            stepQ <= link.scl ? 2'h3 : 2'h2;
                        end
                        default: begin
                            sclOeQ <= 1'b1;
                            stepQ <= 2'h0;
                            txQ <= {txQ[6:0], 1'b0};
                            bitIdxQ <= lastBit ? 4'h0 : bitIdxQ + 4'h1;
                            if (lastBit) begin
                                sdaOeQ <= 1'b0;
                                busyQ <= cmdQ[`CMD_STOP_BIT];
                                stateQ <= cmdQ[`CMD_STOP_BIT] ? H_STOP : H_IDLE;
                            end
                        end
                    endcase
                end
                H_STOP: begin
                    case (stepQ)
                        2'h0: begin
                            sdaOeQ <= 1'b1;
                            stepQ <= 2'h1;
                        end
                        2'h1: begin
                            sclOeQ <= 1'b0;
                            stepQ <= 2'h2;
                        end
                        default: begin
                            sdaOeQ <= 1'b0;
                            stepQ <= 2'h0;
                            busyQ <= 1'b0;
                            stateQ <= H_IDLE;
                        end
                    endcase
                end
                default: begin
                    stepQ <= 2'h0;
                end
            endcase
        end
    end
end

endmodule

// ### tb/serial_rtc_register_access_chk.sv
`timescale 1ns/1ps
`include "rtc_cfg.svh"
module serial_rtc_register_access_chk (
    // Clock and reset
    input wire logic clock,
    input wire logic nrst,
    // Link lines
    input wire logic sdaDevOe,
    input wire logic scl,
    input wire logic sda
);
    logic sclP_q, sdaP_q, addrHit_q, readFr_q;
    logic [3:0] bitCnt_q;
    logic [1:0] byteCnt_q;
    logic [7:0] shift_q;
    wire sclRise = scl && !sclP_q;
    wire startCond = scl && sclP_q && sdaP_q && !sda;
    wire stopCond = scl && sclP_q && !sdaP_q && sda;
    wire ninth = sclRise && (bitCnt_q == 4'h8);
    wire dataByte = ninth && (byteCnt_q != 2'h0) && addrHit_q;

    ////////////////////////////////////////
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            sclP_q <= 1'b1;
            sdaP_q <= 1'b1;
            bitCnt_q <= 4'h0;
            byteCnt_q <= 2'h0;
            addrHit_q <= 1'b0;
            readFr_q <= 1'b0;
            shift_q <= 8'h00;
        end else begin
            sclP_q <= scl;
            sdaP_q <= sda;
            // Conditions win over the clock rise seen just before them
            if (startCond || stopCond) begin
                bitCnt_q <= 4'h0;
                byteCnt_q <= 2'h0;
                addrHit_q <= 1'b0;
            end else if (ninth) begin
                bitCnt_q <= 4'h0;
                byteCnt_q <= (byteCnt_q == 2'h3) ? 2'h3 : byteCnt_q + 2'h1;
                if (byteCnt_q == 2'h0) begin
                    addrHit_q <= (shift_q[7:1] == `DEV_ADDR);
                    readFr_q <= shift_q[0];
                end
            end else if (sclRise) begin
                bitCnt_q <= bitCnt_q + 4'h1;
                shift_q <= {shift_q[6:0], sda};
            end
        end
    end

    ////////////////////////////////////////
    default clocking cb @(posedge clock); endclocking
    default disable iff (!nrst);
    sequence s_nack;
        dataByte && readFr_q && sda;
    endsequence
    property p_addr_ack;
        ninth && (byteCnt_q == 2'h0) |-> sda == (shift_q[7:1] != `DEV_ADDR);
    endproperty
    property p_stranger;
        (byteCnt_q != 2'h0) && !addrHit_q |-> !sdaDevOe;
    endproperty
    property p_write_ack;
        dataByte && !readFr_q |-> !sda;
    endproperty
    property p_read_free;
        dataByte && readFr_q |-> !sdaDevOe;
    endproperty
    property p_nack_release;
        s_nack |=> !sdaDevOe [*8];
    endproperty
    property p_dev_low;
        $changed(sdaDevOe) |-> !scl;
    endproperty
    property p_stop_idle;
        stopCond |=> (scl && sda) [*8];
    endproperty
    property p_start_idle;
        startCond |-> $past(scl, 8);
    endproperty
    a_addr_ack: assert property (p_addr_ack) else $error("address ack wrong");
    a_stranger: assert property (p_stranger) else $error("unaddressed drive");
    a_write_ack: assert property (p_write_ack) else $error("write byte not acked");
    a_read_free: assert property (p_read_free) else $error("device drove ack slot");
    a_nack_release: assert property (p_nack_release) else $error("held after nack");
    a_dev_low: assert property (p_dev_low) else $error("device changed data on high");
    a_stop_idle: assert property (p_stop_idle) else $error("bus not idle after stop");
    a_start_idle: assert property (p_start_idle) else $error("start from busy bus");
endmodule

// ### tb/serial_rtc_register_access_tb_top.sv
`timescale 1ns/1ps
`include "rtc_cfg.svh"
module serial_rtc_register_access_tb_top import rtc_pkg::*;;
    localparam int TICKS = 20;
    logic clock = 1'b0;
    logic nrst = 1'b0;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0, rdata, d;
    logic [3:0] wstrb = 4'hf;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid, haltOsc, failIrqEnable, secondTick;
    logic [1:0] bresp, rresp, r;
    logic [8:0] st;
    byte_t rateTrim;
    int miscompares = 0, testsRun = 0, n;

    rtc_link_if link();
    rtc_host i_rtc_host (.clock(clock), .nrst(nrst), .awaddr(awaddr), .awvalid(awvalid),
        .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
        .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
        .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
        .link(link));
    rtc_device #(.SECOND_TICKS(TICKS)) i_rtc_device (.clock(clock), .nrst(nrst),
        .link(link), .haltOsc(haltOsc), .failIrqEnable(failIrqEnable), .rateTrim(rateTrim),
        .secondTick(secondTick));
    serial_rtc_register_access_chk i_serial_rtc_register_access_chk (.clock(clock),
        .nrst(nrst), .sdaDevOe(link.sdaDevOe), .scl(link.scl), .sda(link.sda));

    initial forever #50 clock = ~clock;

    ////////////////////////////////////////
    task chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        testsRun++;
        if (seen !== exp) begin
            miscompares++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task axiWr(input logic [7:0] a, input logic [31:0] v);
        awaddr <= a;
        wdata <= v;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge clock);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (!bvalid);
        r = bresp;
        bready <= 1'b0;
        // Extra edge so the next task never reassigns in this step
        @(posedge clock);
    endtask
    task axiRd(input logic [7:0] a);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge clock);
            if (arready) arvalid <= 1'b0;
        end while (!rvalid);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
        @(posedge clock);
    endtask
    // Flag bits of f: ack, read, stop, start
    task ser(input logic [3:0] f, input byte_t b);
        axiWr(`CMD_OFS, {20'h0, f, b});
        do axiRd(`STAT_OFS); while (d[9] === 1'b1);
        st = d[8:0];
    endtask

    ////////////////////////////////////////
    task t_host_regs();
        axiRd(`DIV_OFS);
        chk("div reset", d[15:0], `DIV_RESET);
        axiRd(8'h0c);
        chk("rd unmapped", {r, d[13:0]}, {`RESP_SLVERR, 14'h0});
        axiWr(8'h0c, 32'h1);
        chk("wr unmapped", 16'(r), 16'(`RESP_SLVERR));
    endtask
    task t_write();
        ser(4'h1, 8'hd0);
        chk("addr ack", 16'(st), 16'h0d0);
        ser(4'h0, 8'h07);
        chk("word ack", 16'(st), 16'h007);
        ser(4'h0, 8'h5a);
        chk("data ack", 16'(st), 16'h05a);
        ser(4'h2, 8'h80);
        chk("wrap ack", 16'(st), 16'h080);
        chk("trim", 16'(rateTrim), 16'h5a);
        chk("halt", 16'(haltOsc), 16'h1);
        n = 0;
        repeat (3 * TICKS) begin
            @(posedge clock);
            if (secondTick !== 1'b0) n++;
        end
        chk("halted ticks", 16'(n), 16'h0);
    endtask
    task t_stranger();
        ser(4'h3, 8'ha0);
        chk("no ack", 16'(st[8]), 16'h1);
    endtask
    task t_calendar();
        ser(4'h1, 8'hd0);
        ser(4'h0, 8'h01);
        ser(4'h2, 8'h85);
        chk("fail enable", 16'(failIrqEnable), 16'h1);
        ser(4'h1, 8'hd0);
        ser(4'h0, 8'h05);
        ser(4'h0, 8'hc9);
        ser(4'h2, 8'h23);
    endtask
    task t_alt_read();
        ser(4'h1, 8'hd1);
        ser(4'hc, 8'h00);
        chk("alt first", 16'(st), 16'h05a);
        ser(4'hc, 8'h00);
        chk("seconds", 16'(st), 16'h080);
        ser(4'hc, 8'h00);
        chk("minutes", 16'(st), 16'h085);
        ser(4'h6, 8'h00);
        chk("hours", 16'(st), 16'h100);
    endtask
    task t_ptr_read();
        ser(4'h1, 8'hd0);
        ser(4'h0, 8'h05);
        ser(4'h1, 8'hd1);
        ser(4'h6, 8'h00);
        chk("century month", 16'(st), 16'h1c9);
        ser(4'h1, 8'hd1);
        ser(4'h6, 8'h00);
        chk("no advance", 16'(st), 16'h1c9);
    endtask
    task t_run();
        ser(4'h1, 8'hd0);
        ser(4'h0, 8'h00);
        ser(4'h2, 8'h00);
        chk("halt clear", 16'(haltOsc), 16'h0);
        n = 0;
        while (secondTick !== 1'b1 && n < 2 * TICKS + 4) begin
            @(posedge clock);
            n++;
        end
        chk("tick", 16'(secondTick), 16'h1);
    endtask
    task complete_run();
        if (miscompares == 0 && testsRun > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    ////////////////////////////////////////
    initial begin
        repeat (3) @(posedge clock);
        nrst <= 1'b1;
        @(posedge clock);
        t_host_regs();
        t_write();
        t_stranger();
        t_calendar();
        t_alt_read();
        t_ptr_read();
        t_run();
        complete_run();
    end
    initial begin
        repeat (90000) @(posedge clock);
        miscompares++;
        complete_run();
    end
endmodule
